/* hpcp_device.sv */
// hpcp_device: board end of the host packet port, with packet checker,
// command FIFO, return FIFO and error stack.
// assumes the onboard processor and the axis flags share I_REF_CLK.
`timescale 1ns/1ns
// Summary of operation
// - data port writes commands, reads return data
// - two read-only status registers at offsets
// - motion status read live, unbuffered
// - packets: identifier, content, terminator
// - host checks ready-to-receive before each word
// - format errors set packet error immediately
// - only clean complete packets enter FIFO
// - command FIFO holds sixteen commands
// - full FIFO drops ready-to-receive; host waits
// - each command flagged execute or store
// - data and sequence errors set error message
// - return FIFO twenty-six words deep
// - ready-to-send while return data present
// - return packets stay queued in order
// - return overflow raises error message
// - execution errors pushed onto LIFO stack
// - execution errors never touch packet error
// - error entries returned newest first
// - stack holds thirty; extra errors dropped
module hpcp_device #(
   parameter int CMD_DEPTH = hpcp_pkg::CMD_DEPTH,
   parameter int RET_DEPTH = hpcp_pkg::RET_DEPTH,
   parameter int ERR_DEPTH = hpcp_pkg::ERR_DEPTH,
   parameter int MAX_WORDS = hpcp_pkg::MAX_WORDS,
   parameter int NUM_AXES = hpcp_pkg::NUM_AXES
) (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   hpcp_if.device bus,
   input wire logic [NUM_AXES-1:0] I_AXIS_DONE,
   output logic O_CMD_VALID,
   output logic [MAX_WORDS*16-1:0] O_CMD_WORDS,
   output logic [hpcp_pkg::CNT_W-1:0] O_CMD_COUNT,
   output logic O_CMD_STORE,
   input wire logic I_CMD_POP,
   input wire logic I_RET_VALID,
   input wire logic [15:0] I_RET_WORD,
   input wire logic I_ERR_VALID,
   input wire logic [7:0] I_ERR_CMD_ID,
   input wire logic [3:0] I_ERR_RES,
   input wire logic [3:0] I_ERR_CODE,
   input wire logic I_ERR_READ
);
   // ==========================================================
   // helpers
   function automatic logic [hpcp_pkg::PTR_W-1:0] ptr_inc(input logic [hpcp_pkg::PTR_W-1:0] p,
                                                         input int depth);
      ptr_inc = (p == hpcp_pkg::PTR_W'(depth - 1)) ? '0 : hpcp_pkg::PTR_W'(p + 1'b1);
   endfunction : ptr_inc

   typedef enum logic [1:0] {HPCP_RX_ID = 2'b00, HPCP_RX_BODY = 2'b01, HPCP_RX_TERM = 2'b11} hpcp_rx_e;
   localparam int CMD_AW = $clog2(CMD_DEPTH);   // command memories need fewer index bits than the pointers

   // ==========================================================
   // state
   hpcp_rx_e rx_reg, rx_next;
   logic [MAX_WORDS*16-1:0] asm_reg, asm_next;
   logic [hpcp_pkg::CNT_W-1:0] len_reg, len_next, idx_reg, idx_next;
   logic perr_reg, perr_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [MAX_WORDS*16-1:0] cmd_mem [CMD_DEPTH];
   logic [hpcp_pkg::CNT_W-1:0] cmd_len_mem [CMD_DEPTH];
   logic [hpcp_pkg::PTR_W-1:0] cmd_wp_reg, cmd_wp_next, cmd_rp_reg, cmd_rp_next, cmd_lvl_reg, cmd_lvl_next;
   logic [15:0] ret_mem [RET_DEPTH];
   logic [hpcp_pkg::PTR_W-1:0] ret_wp_reg, ret_wp_next, ret_rp_reg, ret_rp_next, ret_lvl_reg, ret_lvl_next;
   logic [15:0] err_mem [ERR_DEPTH];
   logic [hpcp_pkg::PTR_W-1:0] sp_reg, sp_next;
   logic word_in, csr_read, fmt_err, cmd_push, cmd_pop, cmd_full;
   logic ret_push, ret_pop, ret_full, ret_ovf, err_pop, err_push, err_wr;
   logic [15:0] ret_word, err_word;
   logic [hpcp_pkg::PTR_W-1:0] err_addr;
   logic ready_to_receive_flag, rts, emsg;

   // ==========================================================
   // bus decode and status flags
   assign word_in = bus.wr && (bus.addr == hpcp_pkg::ADDR_DATA);
   assign csr_read = bus.rd && (bus.addr == hpcp_pkg::ADDR_CSR);
   assign cmd_full = (cmd_lvl_reg == hpcp_pkg::PTR_W'(CMD_DEPTH));
   assign ret_full = (ret_lvl_reg == hpcp_pkg::PTR_W'(RET_DEPTH));
   assign ready_to_receive_flag = !cmd_full;
   assign rts = (ret_lvl_reg != '0);
   assign emsg = (sp_reg != '0);
   assign bus.rdata = rdata_reg;

   // ==========================================================
   // packet receiver: framing check, then hand complete packets over
   always_comb begin
      rx_next = rx_reg;
      asm_next = asm_reg;
      len_next = len_reg;
      idx_next = idx_reg;
      fmt_err = 1'b0;
      cmd_push = 1'b0;
      if (word_in && !ready_to_receive_flag) begin
         fmt_err = 1'b1;                                             // a word pushed past a full FIFO is lost
         rx_next = HPCP_RX_ID;
      end else if (word_in) begin
         case (rx_reg)
            HPCP_RX_ID: begin
               if (bus.wdata[15:8] == hpcp_pkg::PKT_ID_TAG && bus.wdata[7:0] != 8'h00 &&
                   bus.wdata[7:0] <= 8'(MAX_WORDS)) begin
                  len_next = bus.wdata[hpcp_pkg::CNT_W-1:0];
                  idx_next = '0;
                  rx_next = HPCP_RX_BODY;
               end else begin
                  fmt_err = 1'b1;
               end
            end
            HPCP_RX_BODY: begin
               asm_next[idx_reg*16 +: 16] = bus.wdata;
               idx_next = hpcp_pkg::CNT_W'(idx_reg + 1'b1);
               if (idx_next == len_reg) begin
                  rx_next = HPCP_RX_TERM;
               end
            end
            HPCP_RX_TERM: begin
               if (bus.wdata == hpcp_pkg::PKT_TERM_WORD) begin
                  cmd_push = 1'b1;
               end else begin
                  fmt_err = 1'b1;
               end
               rx_next = HPCP_RX_ID;
            end
            default: begin
               rx_next = HPCP_RX_ID;
            end
         endcase
      end
      // set wins over the clear-on-read of the status register
      perr_next = (perr_reg && !csr_read) || fmt_err;
   end

   // ==========================================================
   // command FIFO bookkeeping
   assign cmd_pop = I_CMD_POP && (cmd_lvl_reg != '0);
   always_comb begin
      cmd_wp_next = cmd_push ? ptr_inc(cmd_wp_reg, CMD_DEPTH) : cmd_wp_reg;
      cmd_rp_next = cmd_pop ? ptr_inc(cmd_rp_reg, CMD_DEPTH) : cmd_rp_reg;
      cmd_lvl_next = cmd_lvl_reg;
      if (cmd_push && !cmd_pop) begin
         cmd_lvl_next = hpcp_pkg::PTR_W'(cmd_lvl_reg + 1'b1);
      end else if (!cmd_push && cmd_pop) begin
         cmd_lvl_next = hpcp_pkg::PTR_W'(cmd_lvl_reg - 1'b1);
      end
   end
   assign O_CMD_VALID = (cmd_lvl_reg != '0);
   assign O_CMD_WORDS = cmd_mem[CMD_AW'(cmd_rp_reg)];
   assign O_CMD_COUNT = cmd_len_mem[CMD_AW'(cmd_rp_reg)];
   assign O_CMD_STORE = O_CMD_WORDS[hpcp_pkg::STORE_FLAG_BIT];

   // ==========================================================
   // return FIFO: processor data first, error entries when the path is free
   always_comb begin
      ret_pop = bus.rd && (bus.addr == hpcp_pkg::ADDR_DATA) && rts;
      ret_ovf = I_RET_VALID && ret_full && !ret_pop;
      err_pop = I_ERR_READ && !I_RET_VALID && emsg && (!ret_full || ret_pop);
      ret_push = (I_RET_VALID && !ret_ovf) || err_pop;
      ret_word = I_RET_VALID ? I_RET_WORD : err_mem[hpcp_pkg::PTR_W'(sp_reg - 1'b1)];
      ret_wp_next = ret_push ? ptr_inc(ret_wp_reg, RET_DEPTH) : ret_wp_reg;
      ret_rp_next = ret_pop ? ptr_inc(ret_rp_reg, RET_DEPTH) : ret_rp_reg;
      ret_lvl_next = ret_lvl_reg;
      if (ret_push && !ret_pop) begin
         ret_lvl_next = hpcp_pkg::PTR_W'(ret_lvl_reg + 1'b1);
      end else if (!ret_push && ret_pop) begin
         ret_lvl_next = hpcp_pkg::PTR_W'(ret_lvl_reg - 1'b1);
      end
   end

   // ==========================================================
   // error stack: push, pop, or both (new entry replaces the popped top)
   always_comb begin
      err_push = I_ERR_VALID || ret_ovf;
      err_word = I_ERR_VALID ? {I_ERR_CMD_ID, I_ERR_RES, I_ERR_CODE}
                             : {hpcp_pkg::ERR_ID_RETURN, hpcp_pkg::ERR_RES_NONE, hpcp_pkg::ERR_CODE_RET_FULL};
      sp_next = sp_reg;
      err_wr = 1'b0;
      err_addr = sp_reg;
      if (err_push && err_pop) begin
         err_wr = 1'b1;
         err_addr = hpcp_pkg::PTR_W'(sp_reg - 1'b1);
      end else if (err_push && sp_reg != hpcp_pkg::PTR_W'(ERR_DEPTH)) begin
         err_wr = 1'b1;
         sp_next = hpcp_pkg::PTR_W'(sp_reg + 1'b1);
      end else if (err_pop) begin
         sp_next = hpcp_pkg::PTR_W'(sp_reg - 1'b1);
      end
   end

   // ==========================================================
   // read data: captured on the strobe, held otherwise
   always_comb begin
      rdata_next = rdata_reg;
      if (bus.rd) begin
         rdata_next = hpcp_pkg::WORD_ZERO;
         case (bus.addr)
            hpcp_pkg::ADDR_DATA: begin
               if (rts) begin
                  rdata_next = ret_mem[ret_rp_reg];
               end
            end
            hpcp_pkg::ADDR_CSR: begin
               rdata_next[hpcp_pkg::CSR_READY_RX_BIT] = ready_to_receive_flag;
               rdata_next[hpcp_pkg::CSR_RTS_BIT] = rts;
               rdata_next[hpcp_pkg::CSR_PERR_BIT] = perr_reg;
               rdata_next[hpcp_pkg::CSR_EMSG_BIT] = emsg;
            end
            hpcp_pkg::ADDR_MOTION: begin
               rdata_next[NUM_AXES-1:0] = I_AXIS_DONE;
            end
            default: begin
               rdata_next = hpcp_pkg::WORD_ZERO;
            end
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         rx_reg <= HPCP_RX_ID;
         asm_reg <= '0;
         len_reg <= '0;
         idx_reg <= '0;
         perr_reg <= 1'b0;
         rdata_reg <= hpcp_pkg::WORD_ZERO;
         cmd_wp_reg <= '0;
         cmd_rp_reg <= '0;
         cmd_lvl_reg <= '0;
         ret_wp_reg <= '0;
         ret_rp_reg <= '0;
         ret_lvl_reg <= '0;
         sp_reg <= '0;
      end else begin
         rx_reg <= rx_next;
         asm_reg <= asm_next;
         len_reg <= len_next;
         idx_reg <= idx_next;
         perr_reg <= perr_next;
         rdata_reg <= rdata_next;
         cmd_wp_reg <= cmd_wp_next;
         cmd_rp_reg <= cmd_rp_next;
         cmd_lvl_reg <= cmd_lvl_next;
         ret_wp_reg <= ret_wp_next;
         ret_rp_reg <= ret_rp_next;
         ret_lvl_reg <= ret_lvl_next;
         sp_reg <= sp_next;
      end
   end

   // memories carry no reset; only their pointers need one
   always_ff @(posedge I_REF_CLK) begin
      if (cmd_push) begin
         cmd_mem[CMD_AW'(cmd_wp_reg)] <= asm_reg;
         cmd_len_mem[CMD_AW'(cmd_wp_reg)] <= len_reg;
      end
      if (ret_push) begin
         ret_mem[ret_wp_reg] <= ret_word;
      end
      if (err_wr) begin
         err_mem[err_addr] <= err_word;
      end
   end
endmodule : hpcp_device

/* hpcp_pkg.sv */
// hpcp_pkg: constants shared by both ends of the host packet command port.
// assumes both ends run on the same 25 MHz reference clock.
package hpcp_pkg;
   // ==========================================================
   // port window offsets (word addresses on the host side)
   localparam logic [1:0] ADDR_DATA = 2'h0;
   localparam logic [1:0] ADDR_CSR = 2'h1;
   localparam logic [1:0] ADDR_MOTION = 2'h2;
   // ==========================================================
   // communications status bit positions
   localparam int CSR_READY_RX_BIT = 0;
   localparam int CSR_RTS_BIT = 1;
   localparam int CSR_PERR_BIT = 2;
   localparam int CSR_EMSG_BIT = 3;
   // ==========================================================
   // depths, widths and packet framing
   localparam int WORD_W = 16;
   localparam int PTR_W = 5;
   localparam int CMD_DEPTH = 16;
   localparam int RET_DEPTH = 26;
   localparam int ERR_DEPTH = 30;
   localparam int MAX_WORDS = 4;
   localparam int NUM_AXES = 6;
   localparam int CNT_W = 3;
   localparam logic [7:0] PKT_ID_TAG = 8'hA5;
   localparam logic [15:0] PKT_TERM_WORD = 16'h5AFF;
   localparam int STORE_FLAG_BIT = 15;
   localparam logic [7:0] ERR_ID_RETURN = 8'h00;
   localparam logic [3:0] ERR_RES_NONE = 4'h0;
   localparam logic [3:0] ERR_CODE_RET_FULL = 4'hF;
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
endpackage : hpcp_pkg

/* hpcp_if.sv */
// hpcp_if: the host I/O window between the host end and the board end.
// assumes one shared clock; read data is returned one cycle after the strobe.
`timescale 1ns/1ns
interface hpcp_if;
   logic [1:0] addr;
   logic wr;
   logic rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport device (input addr, input wr, input rd, input wdata, output rdata);
   modport host (output addr, output wr, output rd, output wdata, input rdata);
endinterface : hpcp_if

/* hpcp_host.sv */
// hpcp_host: host end; polls the status register before every data access.
// assumes the board end answers reads one cycle after the strobe.
`timescale 1ns/1ns
module hpcp_host (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   hpcp_if.host bus,
   input wire logic I_SEND_VALID,
   input wire logic [15:0] I_SEND_WORD,
   output logic O_SEND_ACK,
   input wire logic I_RECV_EN,
   output logic O_RECV_VALID,
   output logic [15:0] O_RECV_WORD,
   input wire logic I_MOTION_REQ,
   output logic O_MOTION_VALID,
   output logic [15:0] O_MOTION_WORD,
   output logic [15:0] O_CSR_WORD
);
   // ==========================================================
   // states
   typedef enum logic [2:0] {
      HPCP_H_IDLE = 3'b000, HPCP_H_POLL = 3'b001, HPCP_H_EVAL = 3'b011, HPCP_H_WRITE = 3'b010,
      HPCP_H_READ = 3'b110, HPCP_H_RWAIT = 3'b111, HPCP_H_MREAD = 3'b101, HPCP_H_MWAIT = 3'b100
   } hpcp_h_e;
   hpcp_h_e st_reg, st_next;
   logic [15:0] wdata_reg, wdata_next, recv_reg, recv_next, motion_reg, motion_next, csr_reg, csr_next;

   // ==========================================================
   // sequencer; status is re-read before every single data word
   always_comb begin
      st_next = st_reg;
      wdata_next = wdata_reg;
      recv_next = recv_reg;
      motion_next = motion_reg;
      csr_next = csr_reg;
      case (st_reg)
         HPCP_H_IDLE: begin
            if (I_MOTION_REQ) begin
               st_next = HPCP_H_MREAD;
            end else if (I_SEND_VALID || I_RECV_EN) begin
               st_next = HPCP_H_POLL;
            end
         end
         HPCP_H_POLL: begin
            st_next = HPCP_H_EVAL;
         end
         HPCP_H_EVAL: begin
            csr_next = bus.rdata;
            st_next = HPCP_H_IDLE;
            if (I_SEND_VALID && bus.rdata[hpcp_pkg::CSR_READY_RX_BIT]) begin
               wdata_next = I_SEND_WORD;
               st_next = HPCP_H_WRITE;
            end else if (I_RECV_EN && bus.rdata[hpcp_pkg::CSR_RTS_BIT]) begin
               st_next = HPCP_H_READ;
            end
         end
         HPCP_H_WRITE: begin
            st_next = HPCP_H_IDLE;
         end
         HPCP_H_READ: begin
            st_next = HPCP_H_RWAIT;
         end
         HPCP_H_RWAIT: begin
            recv_next = bus.rdata;
            st_next = HPCP_H_IDLE;
         end
         HPCP_H_MREAD: begin
            st_next = HPCP_H_MWAIT;
         end
         HPCP_H_MWAIT: begin
            motion_next = bus.rdata;
            st_next = HPCP_H_IDLE;
         end
         default: begin
            st_next = HPCP_H_IDLE;
         end
      endcase
   end

   // bus strobes follow the state directly
   assign bus.wr = (st_reg == HPCP_H_WRITE);
   assign bus.rd = (st_reg == HPCP_H_POLL) || (st_reg == HPCP_H_READ) || (st_reg == HPCP_H_MREAD);
   assign bus.addr = (st_reg == HPCP_H_POLL) ? hpcp_pkg::ADDR_CSR :
                     (st_reg == HPCP_H_MREAD) ? hpcp_pkg::ADDR_MOTION : hpcp_pkg::ADDR_DATA;
   assign bus.wdata = wdata_reg;
   assign O_SEND_ACK = (st_reg == HPCP_H_WRITE);
   assign O_RECV_VALID = (st_reg == HPCP_H_RWAIT);
   assign O_MOTION_VALID = (st_reg == HPCP_H_MWAIT);
   assign O_RECV_WORD = recv_reg;
   assign O_MOTION_WORD = motion_reg;
   assign O_CSR_WORD = csr_reg;

   // ==========================================================
   // registers
   always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
         st_reg <= HPCP_H_IDLE;
         wdata_reg <= hpcp_pkg::WORD_ZERO;
         recv_reg <= hpcp_pkg::WORD_ZERO;
         motion_reg <= hpcp_pkg::WORD_ZERO;
         csr_reg <= hpcp_pkg::WORD_ZERO;
      end else begin
         st_reg <= st_next;
         wdata_reg <= wdata_next;
         recv_reg <= recv_next;
         motion_reg <= motion_next;
         csr_reg <= csr_next;
      end
   end
endmodule : hpcp_host

/* hpcp_properties.sv */
// hpcp_properties: timing checks on the host window between the two ends.
// assumes one shared clock; tb instantiates it beside the joining interface.
`timescale 1ns/1ns
module hpcp_properties (
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic [1:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata
);
   // ==========================================================
   // window checks, single clock domain
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RESET);

   property p_one_strobe;
      !(wr && rd);
   endproperty
   a_one_strobe: assert property (p_one_strobe)
      else $error("read and write strobes high together");
   property p_rd_pulse;
      rd |=> !rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe longer than one cycle");
   // every data write must follow its own status poll two cycles earlier
   property p_poll_first;
      wr && addr == hpcp_pkg::ADDR_DATA |-> $past(rd, 2) && $past(addr, 2) == hpcp_pkg::ADDR_CSR;
   endproperty
   a_poll_first: assert property (p_poll_first)
      else $error("data write without a preceding status poll");
   property p_wr_ready;
      wr && addr == hpcp_pkg::ADDR_DATA |-> rdata[hpcp_pkg::CSR_READY_RX_BIT];
   endproperty
   a_wr_ready: assert property (p_wr_ready)
      else $error("data write while not ready to receive");
   property p_rd_rts;
      rd && addr == hpcp_pkg::ADDR_DATA |-> rdata[hpcp_pkg::CSR_RTS_BIT] && $past(addr, 2) == hpcp_pkg::ADDR_CSR;
   endproperty
   a_rd_rts: assert property (p_rd_rts)
      else $error("data read while nothing ready to send");
   property p_csr_top;
      rd && addr == hpcp_pkg::ADDR_CSR |=> rdata[15:4] == 12'h000;
   endproperty
   a_csr_top: assert property (p_csr_top)
      else $error("status word has unused bits set");
   // read data must hold between strobes, otherwise the host latches junk
   property p_hold;
      !$past(rd) |-> $stable(rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data changed without a read strobe");
   property p_wr_addr;
      wr |-> addr == hpcp_pkg::ADDR_DATA;
   endproperty
   a_wr_addr: assert property (p_wr_addr)
      else $error("write to a read-only status register");
endmodule : hpcp_properties

/* tb.sv */
// tb: drives the user sides of the joined host and board ends.
// assumes default depths; the window checker sits beside the interface.
`timescale 1ns/1ns
module tb;
   logic ref_clk, reset, send_valid, send_ack, recv_en, recv_valid, motion_req, motion_valid;
   logic cmd_valid, cmd_store, cmd_pop, ret_valid, err_valid, err_read, seen;
   logic [15:0] send_word, recv_word, motion_word, csr_word, ret_word, first_csr, w;
   logic [63:0] cmd_words;
   logic [2:0] cmd_count;
   logic [7:0] err_id;
   logic [3:0] err_res, err_code;
   logic [5:0] axis;
   logic [63:0] q_cmd[$];
   logic [2:0] q_cnt[$];
   logic [15:0] q_ret[$];
   logic [15:0] q_err[$];
   int n_mismatch = 0;
   int num_checks = 0;

   // ==========================================================
   // the two ends joined by one window, checker beside it
   hpcp_if bus();
   hpcp_device i_hpcp_device (.I_REF_CLK(ref_clk), .I_RESET(reset), .bus(bus), .I_AXIS_DONE(axis),
      .O_CMD_VALID(cmd_valid), .O_CMD_WORDS(cmd_words), .O_CMD_COUNT(cmd_count), .O_CMD_STORE(cmd_store),
      .I_CMD_POP(cmd_pop), .I_RET_VALID(ret_valid), .I_RET_WORD(ret_word), .I_ERR_VALID(err_valid),
      .I_ERR_CMD_ID(err_id), .I_ERR_RES(err_res), .I_ERR_CODE(err_code), .I_ERR_READ(err_read));
   hpcp_host i_hpcp_host (.I_REF_CLK(ref_clk), .I_RESET(reset), .bus(bus), .I_SEND_VALID(send_valid),
      .I_SEND_WORD(send_word), .O_SEND_ACK(send_ack), .I_RECV_EN(recv_en), .O_RECV_VALID(recv_valid),
      .O_RECV_WORD(recv_word), .I_MOTION_REQ(motion_req), .O_MOTION_VALID(motion_valid),
      .O_MOTION_WORD(motion_word),
      .O_CSR_WORD(csr_word));
   hpcp_properties i_hpcp_properties (.I_REF_CLK(ref_clk), .I_RESET(reset), .addr(bus.addr), .wr(bus.wr),
      .rd(bus.rd), .rdata(bus.rdata));

   // ==========================================================
   // clock, watchdog and verdict
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // generous bound: the full sequence needs well under 5000 cycles
   initial begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // helpers; every task enters and leaves 1 ns after a rising edge
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   function automatic logic [63:0] mask(input int n);
      return (64'h1 << (n * 16)) - 64'h1;
   endfunction : mask
   function automatic logic done_sig(input int k);
      return (k == 0) ? send_ack : ((k == 1) ? recv_valid : motion_valid);
   endfunction : done_sig
   // acks are pulses, so they are looked at mid-cycle, never on the edge
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      while (done_sig(k) !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 300) n_mismatch++;
      step();
   endtask : wait_hi
   // requests stay raised so back-to-back calls never assign twice in one step
   task automatic send_w(input logic [15:0] v);
      send_valid = 1'b1;
      send_word = v;
      wait_hi(0);
   endtask : send_w
   task automatic hreq(input int k, output logic [15:0] v);
      if (k == 1) recv_en = 1'b1;
      else motion_req = 1'b1;
      wait_hi(k);
      v = (k == 1) ? recv_word : motion_word;
   endtask : hreq
   task automatic quiet();
      send_valid = 1'b0;
      recv_en = 1'b0;
      motion_req = 1'b0;
   endtask : quiet
   task automatic pkt(input int n);
      logic [63:0] c;
      c = '0;
      send_w({hpcp_pkg::PKT_ID_TAG, 8'(n)});
      first_csr = csr_word;
      for (int i = 0; i < n; i++) begin
         c[i*16 +: 16] = 16'($urandom);
         send_w(c[i*16 +: 16]);
      end
      send_w(hpcp_pkg::PKT_TERM_WORD);
      q_cmd.push_back(c);
      q_cnt.push_back(3'(n));
   endtask : pkt
   task automatic pop_chk();
      logic [63:0] c;
      logic [2:0] n;
      c = q_cmd.pop_front();
      n = q_cnt.pop_front();
      chk(cmd_valid, 1'b1);
      chk(cmd_count, n);
      chk(cmd_words & mask(n), c);
      chk(cmd_store, c[hpcp_pkg::STORE_FLAG_BIT]);
      cmd_pop = 1'b1;
      step();
      cmd_pop = 1'b0;
      step();
   endtask : pop_chk

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(61158));
      reset = 1'b1;
      {send_word, ret_word, err_id, err_res, err_code, axis} = '0;
      {send_valid, recv_en, motion_req, cmd_pop, ret_valid, err_valid, err_read} = 7'h00;
      repeat (2) @(posedge ref_clk);
      #1 reset = 1'b0;
      // every legal length, then each kind of malformed packet
      for (int n = 1; n <= hpcp_pkg::MAX_WORDS; n++) pkt(n);
      chk(first_csr[hpcp_pkg::CSR_PERR_BIT], 1'b0);
      send_w(16'hA505);
      pkt(2);
      chk(first_csr[hpcp_pkg::CSR_PERR_BIT], 1'b1);
      send_w(16'hA500);
      pkt(1);
      chk(first_csr[hpcp_pkg::CSR_PERR_BIT], 1'b1);
      send_w(16'h5A01);
      pkt(1);
      chk(first_csr[hpcp_pkg::CSR_PERR_BIT], 1'b1);
      send_w(16'hA501);
      send_w(16'h0000);
      send_w(16'h1234);
      pkt(3);
      chk(first_csr[hpcp_pkg::CSR_PERR_BIT], 1'b1);
      quiet();
      while (q_cmd.size() > 0) pop_chk();
      chk(cmd_valid, 1'b0);
      // fill the command fifo; the next packet must stall until a pop
      for (int i = 0; i < hpcp_pkg::CMD_DEPTH; i++) pkt(1);
      send_valid = 1'b1;
      send_word = 16'hA501;
      seen = 1'b0;
      repeat (24) @(negedge ref_clk) if (send_ack === 1'b1) seen = 1'b1;
      chk(seen, 1'b0);
      chk(csr_word[hpcp_pkg::CSR_READY_RX_BIT], 1'b0);
      step();
      pop_chk();
      send_w(16'hA501);
      send_w(16'h0042);
      send_w(hpcp_pkg::PKT_TERM_WORD);
      quiet();
      q_cmd.push_back(64'h0042);
      q_cnt.push_back(3'd1);
      while (q_cmd.size() > 0) pop_chk();
      // return fifo: one word past full, then drain in order
      for (int i = 0; i <= hpcp_pkg::RET_DEPTH; i++) begin
         ret_valid = 1'b1;
         ret_word = 16'($urandom);
         if (i < hpcp_pkg::RET_DEPTH) q_ret.push_back(ret_word);
         step();
      end
      ret_valid = 1'b0;
      for (int i = 0; i < hpcp_pkg::RET_DEPTH; i++) begin
         hreq(1, w);
         chk(w, q_ret.pop_front());
         chk(csr_word[hpcp_pkg::CSR_RTS_BIT], 1'b1);
         if (i == 0) chk(csr_word[hpcp_pkg::CSR_EMSG_BIT], 1'b1);
      end
      quiet();
      err_read = 1'b1;
      step();
      err_read = 1'b0;
      hreq(1, w);
      quiet();
      chk(w, {hpcp_pkg::ERR_ID_RETURN, hpcp_pkg::ERR_RES_NONE, hpcp_pkg::ERR_CODE_RET_FULL});
      chk(csr_word[hpcp_pkg::CSR_EMSG_BIT], 1'b0);
      // error stack: one entry past full, then read back newest first
      for (int i = 0; i <= hpcp_pkg::ERR_DEPTH; i++) begin
         err_valid = 1'b1;
         {err_id, err_res, err_code} = 16'($urandom);
         if (i < hpcp_pkg::ERR_DEPTH) q_err.push_back({err_id, err_res, err_code});
         step();
      end
      err_valid = 1'b0;
      for (int i = 0; i < hpcp_pkg::ERR_DEPTH; i++) begin
         err_read = 1'b1;
         step();
         err_read = 1'b0;
         hreq(1, w);
         quiet();
         chk(w, q_err.pop_back());
         chk(csr_word[hpcp_pkg::CSR_EMSG_BIT], q_err.size() != 0);
         chk(csr_word[hpcp_pkg::CSR_PERR_BIT], 1'b0);
      end
      // one more poll after the last word: nothing may be left to send
      step();
      recv_en = 1'b1;
      repeat (4) step();
      recv_en = 1'b0;
      chk(csr_word[hpcp_pkg::CSR_RTS_BIT], 1'b0);
      // motion status follows the axis flags at the moment of the read
      for (int i = 0; i < 4; i++) begin
         axis = (i == 0) ? 6'h3F : 6'($urandom);
         hreq(2, w);
         chk(w, {10'h000, axis});
      end
      quiet();
      report_and_stop();
   end
endmodule : tb
